//--- verilog/napc_device.sv
// device end: receive fifo, packet check and field codec
// Behaviour
// [RULE1] id 50 read only, 12 byte magnetic field
// [RULE2] id 51 read only, 20 byte odometer state
// [RULE3] id 52 read only, 8 byte time
// [RULE4] id 53 read write, depth and deviation
// [RULE5] depth positive means below mean sea level
// [RULE6] id 54 read only, 4 byte geoid height
// [RULE7] msl height and depth derived from geoid height
// [RULE8] id 55 write only, rtcm bytes passed opaque
// [RULE9] id 57 read write, wind north east deviation
// [RULE10] wind write freezes estimator to written values
// [RULE11] wind valid only with external air data
// [RULE12] id 58 read only, four heave points
// [RULE13] bad length or read-only write is discarded
`timescale 1ns/1ps
`include "napc_map.svh"
module napc_fifo
   import napc_pkg::*;
#(
   parameter int W = `NAPC_FIFO_WIDTH,
   parameter int DEPTH = `NAPC_FIFO_DEPTH
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } napc_fifo_s;
   napc_fifo_s s_r;
   napc_fifo_s s_nxt;
   logic full;
   logic empty;

   assign empty = (s_r.wp == s_r.rp);
   assign full = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = s_r.mem[s_r.rp[AW-1:0]];

   always_comb begin
      s_nxt = s_r;
      if (i_in_valid && !full) begin
         s_nxt.mem[s_r.wp[AW-1:0]] = i_in_data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (i_out_ready && !empty) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

module napc_device
   import napc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   napc_link_if.dev link,
   input wire logic [95:0] i_mag_xyz,
   input wire logic [159:0] i_odo_state,
   input wire logic [63:0] i_ext_time,
   input wire logic [31:0] i_geoid_height,
   input wire logic [95:0] i_wind_est,
   input wire logic [127:0] i_heave,
   input wire logic i_air_data_valid,
   output logic [31:0] o_depth,
   output logic [31:0] o_depth_sd,
   output logic o_depth_update,
   output logic [95:0] o_wind_fixed_val,
   output logic o_wind_fixed,
   output logic o_wind_valid,
   output logic o_rtcm_valid,
   output logic [7:0] o_rtcm_data,
   input wire logic i_rtcm_ready
);
   typedef struct packed {
      napc_dev_e st;
      logic [7:0] id;
      logic [7:0] len;
      logic [7:0] cnt;
      napc_wpay_t wbuf;
      napc_pay_t tbuf;
      logic [7:0] txd;
      logic [63:0] depth;
      logic depth_upd;
      logic [95:0] wind;
      logic wind_fixed;
      logic wind_valid;
      logic rt_v;
      logic [7:0] rt_d;
   } napc_dev_s;
   napc_dev_s s_r;
   napc_dev_s s_nxt;
   logic f_valid;
   logic f_ready;
   logic [8:0] f_word;
   logic [7:0] f_data;
   logic f_last;
   logic rx_st;
   logic rt_stall;
   napc_pay_t rd_pay;

   napc_fifo #(.W(`NAPC_FIFO_WIDTH), .DEPTH(`NAPC_FIFO_DEPTH)) u_rx_fifo (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_in_valid(link.h2d_valid),
      .o_in_ready(link.h2d_ready),
      .i_in_data({link.h2d_last, link.h2d_data}),
      .o_out_valid(f_valid),
      .i_out_ready(f_ready),
      .o_out_data(f_word)
   );

   assign f_data = f_word[7:0];
   assign f_last = f_word[8];
   assign rx_st = (s_r.st == DV_ID) || (s_r.st == DV_LEN) || (s_r.st == DV_PAY) ||
      (s_r.st == DV_DROP);
   // rtcm sink back-pressure stalls the fifo drain, never drops a byte
   assign rt_stall = (s_r.st == DV_PAY) && (s_r.id == `NAPC_ID_RTCM) && s_r.rt_v && !i_rtcm_ready;
   assign f_ready = rx_st && !rt_stall;

   assign link.d2h_valid = (s_r.st == DV_TID) || (s_r.st == DV_TLEN) || (s_r.st == DV_TPAY);
   assign link.d2h_data = s_r.txd;
   assign link.d2h_last = (s_r.st == DV_TPAY) && (s_r.cnt + 8'h01 == s_r.len);

   assign o_depth = s_r.depth[31:0];
   assign o_depth_sd = s_r.depth[63:32];
   assign o_depth_update = s_r.depth_upd;
   assign o_wind_fixed_val = s_r.wind;
   assign o_wind_fixed = s_r.wind_fixed;
   assign o_wind_valid = s_r.wind_valid;
   assign o_rtcm_valid = s_r.rt_v;
   assign o_rtcm_data = s_r.rt_d;

   // read payloads, byte 0 of each field vector is payload offset 0
   always_comb begin
      rd_pay = '0;
      case (s_r.id)
         `NAPC_ID_MAG: rd_pay[11:0] = i_mag_xyz; // RULE1
         `NAPC_ID_ODO: rd_pay = {24'h000000, i_odo_state[135:0]}; // RULE2
         `NAPC_ID_TIME: rd_pay[7:0] = i_ext_time; // RULE3
         `NAPC_ID_DEPTH: rd_pay[7:0] = s_r.depth; // RULE4
         `NAPC_ID_GEOID: rd_pay[3:0] = i_geoid_height; // RULE6
         `NAPC_ID_WIND: rd_pay[11:0] = s_r.wind_fixed ? s_r.wind : i_wind_est; // RULE9
         `NAPC_ID_HEAVE: rd_pay[15:0] = i_heave; // RULE12
         default: rd_pay = '0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.depth_upd = 1'b0;
      s_nxt.wind_valid = i_air_data_valid; // RULE11
      if (s_r.rt_v && i_rtcm_ready) begin
         s_nxt.rt_v = 1'b0;
      end
      case (s_r.st)
         DV_ID: begin
            if (f_valid) begin
               s_nxt.id = f_data;
               s_nxt.st = f_last ? DV_ID : DV_LEN;
            end
         end
         DV_LEN: begin
            if (f_valid) begin
               s_nxt.len = f_data;
               s_nxt.cnt = 8'h00;
               if (f_last) begin
                  // zero length is a read request; read of a write-only id is dropped
                  if (f_data == 8'h00 && napc_readable(s_r.id)) begin
                     s_nxt.tbuf = rd_pay;
                     s_nxt.txd = s_r.id;
                     s_nxt.st = DV_TID;
                  end else begin
                     s_nxt.st = DV_ID; // RULE13
                  end
               end else if (napc_write_ok(s_r.id, f_data)) begin
                  s_nxt.st = DV_PAY;
               end else begin
                  s_nxt.st = DV_DROP; // RULE13
               end
            end
         end
         DV_PAY: begin
            if (f_valid && f_ready) begin
               s_nxt.cnt = s_r.cnt + 8'h01;
               if (s_r.id == `NAPC_ID_RTCM) begin
                  s_nxt.rt_v = 1'b1; // RULE8
                  s_nxt.rt_d = f_data;
               end else begin
                  s_nxt.wbuf[s_r.cnt[3:0]] = f_data;
               end
               if (f_last) begin
                  s_nxt.st = DV_ID;
                  // commit only when the frame ended exactly at its length
                  if (s_r.cnt + 8'h01 == s_r.len) begin // RULE13
                     if (s_r.id == `NAPC_ID_DEPTH) begin
                        // positive depth is below mean sea level; stored as sent
                        s_nxt.depth = {s_nxt.wbuf[7:4], s_nxt.wbuf[3:0]}; // RULE4 RULE5
                        s_nxt.depth_upd = 1'b1;
                     end else if (s_r.id == `NAPC_ID_WIND) begin
                        s_nxt.wind = s_nxt.wbuf; // RULE9
                        s_nxt.wind_fixed = 1'b1; // RULE10
                     end
                  end
               end else if (s_r.cnt + 8'h01 == s_r.len) begin
                  s_nxt.st = DV_DROP; // RULE13
               end
            end
         end
         DV_DROP: begin
            if (f_valid && f_last) begin
               s_nxt.st = DV_ID;
            end
         end
         DV_TID: begin
            if (link.d2h_ready) begin
               s_nxt.len = napc_len(s_r.id);
               s_nxt.txd = napc_len(s_r.id);
               s_nxt.st = DV_TLEN;
            end
         end
         DV_TLEN: begin
            if (link.d2h_ready) begin
               s_nxt.cnt = 8'h00;
               s_nxt.txd = s_r.tbuf[0];
               s_nxt.st = DV_TPAY;
            end
         end
         DV_TPAY: begin
            if (link.d2h_ready) begin
               s_nxt.cnt = s_r.cnt + 8'h01;
               s_nxt.txd = s_r.tbuf[s_nxt.cnt[4:0]];
               if (s_r.cnt + 8'h01 == s_r.len) begin
                  s_nxt.st = DV_ID;
               end
            end
         end
         default: s_nxt.st = DV_ID;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

//--- verilog/napc_map.svh
// packet ids, payload lengths and buffer sizes for the aux packet codec
`ifndef NAPC_MAP_SVH
`define NAPC_MAP_SVH
`define NAPC_ID_MAG 8'h32
`define NAPC_ID_ODO 8'h33
`define NAPC_ID_TIME 8'h34
`define NAPC_ID_DEPTH 8'h35
`define NAPC_ID_GEOID 8'h36
`define NAPC_ID_RTCM 8'h37
`define NAPC_ID_WIND 8'h39
`define NAPC_ID_HEAVE 8'h3A
`define NAPC_LEN_MAG 8'h0C
`define NAPC_LEN_ODO 8'h14
`define NAPC_LEN_TIME 8'h08
`define NAPC_LEN_DEPTH 8'h08
`define NAPC_LEN_GEOID 8'h04
`define NAPC_LEN_RTCM_MAX 8'hFF
`define NAPC_LEN_WIND 8'h0C
`define NAPC_LEN_HEAVE 8'h10
`define NAPC_FIFO_DEPTH 32
`define NAPC_FIFO_WIDTH 9
`endif

//--- verilog/napc_pkg.sv
// types and packet table lookups shared by both ends of the codec
`include "napc_map.svh"
package napc_pkg;
   typedef logic [19:0][7:0] napc_pay_t;
   typedef logic [11:0][7:0] napc_wpay_t;
   typedef enum logic [2:0] {DV_ID, DV_LEN, DV_PAY, DV_DROP, DV_TID, DV_TLEN, DV_TPAY} napc_dev_e;
   typedef enum logic [1:0] {HT_IDLE, HT_ID, HT_LEN, HT_PAY} napc_htx_e;
   typedef enum logic [1:0] {HR_ID, HR_LEN, HR_PAY} napc_hrx_e;

   function automatic logic [7:0] napc_len(input logic [7:0] id);
      case (id)
         `NAPC_ID_MAG: napc_len = `NAPC_LEN_MAG;
         `NAPC_ID_ODO: napc_len = `NAPC_LEN_ODO;
         `NAPC_ID_TIME: napc_len = `NAPC_LEN_TIME;
         `NAPC_ID_DEPTH: napc_len = `NAPC_LEN_DEPTH;
         `NAPC_ID_GEOID: napc_len = `NAPC_LEN_GEOID;
         `NAPC_ID_WIND: napc_len = `NAPC_LEN_WIND;
         `NAPC_ID_HEAVE: napc_len = `NAPC_LEN_HEAVE;
         default: napc_len = 8'h00;
      endcase
   endfunction

   function automatic logic napc_readable(input logic [7:0] id);
      napc_readable = (napc_len(id) != 8'h00);
   endfunction

   function automatic logic napc_writable(input logic [7:0] id);
      napc_writable = (id == `NAPC_ID_DEPTH) || (id == `NAPC_ID_WIND) || (id == `NAPC_ID_RTCM);
   endfunction

   // rtcm is variable, 1 to 255 bytes; the 8-bit length field caps it
   function automatic logic napc_write_ok(input logic [7:0] id, input logic [7:0] len);
      if (id == `NAPC_ID_RTCM) begin
         napc_write_ok = (len != 8'h00) && (len <= `NAPC_LEN_RTCM_MAX);
      end else begin
         napc_write_ok = napc_writable(id) && (len == napc_len(id));
      end
   endfunction
endpackage

//--- verilog/napc_link_if.sv
// byte stream link between host and device ends
`timescale 1ns/1ps
interface napc_link_if;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] h2d_data;
   logic h2d_last;
   logic d2h_valid;
   logic d2h_ready;
   logic [7:0] d2h_data;
   logic d2h_last;
   modport dev (input h2d_valid, h2d_data, h2d_last, d2h_ready,
      output h2d_ready, d2h_valid, d2h_data, d2h_last);
   modport host (output h2d_valid, h2d_data, h2d_last, d2h_ready,
      input h2d_ready, d2h_valid, d2h_data, d2h_last);
endinterface

//--- verilog/napc_host.sv
// host end: command issue, rtcm pass-through and response capture
`timescale 1ns/1ps
`include "napc_map.svh"
module napc_host
   import napc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   napc_link_if.host link,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic i_cmd_write,
   input wire logic [7:0] i_cmd_id,
   input wire logic [7:0] i_cmd_len,
   input wire logic [95:0] i_cmd_payload,
   output logic o_cmd_err,
   input wire logic i_rtcm_valid,
   input wire logic [7:0] i_rtcm_data,
   output logic o_rtcm_ready,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_id,
   output logic [159:0] o_rsp_payload
);
   typedef struct packed {
      napc_htx_e tx;
      logic wr;
      logic [7:0] id;
      logic [7:0] len;
      logic [7:0] cnt;
      napc_wpay_t pay;
      logic tv;
      logic [7:0] txd;
      logic tl;
      logic cmd_err;
      napc_hrx_e rx;
      logic [7:0] rid;
      logic [7:0] rlen;
      logic [7:0] rcnt;
      napc_pay_t rbuf;
      logic rsp_v;
      logic [7:0] rsp_id;
      napc_pay_t rsp;
   } napc_host_s;
   napc_host_s s_r;
   napc_host_s s_nxt;
   logic load;
   logic rt_src;

   // output stage refills when empty or when the device takes the byte
   assign load = !s_r.tv || link.h2d_ready;
   assign rt_src = (s_r.tx == HT_PAY) && (s_r.id == `NAPC_ID_RTCM);
   assign o_cmd_ready = (s_r.tx == HT_IDLE);
   assign o_rtcm_ready = load && rt_src;
   assign o_cmd_err = s_r.cmd_err;
   assign link.h2d_valid = s_r.tv;
   assign link.h2d_data = s_r.txd;
   assign link.h2d_last = s_r.tl;
   assign link.d2h_ready = 1'b1;
   assign o_rsp_valid = s_r.rsp_v;
   assign o_rsp_id = s_r.rsp_id;
   assign o_rsp_payload = s_r.rsp;

   always_comb begin
      s_nxt = s_r;
      s_nxt.cmd_err = 1'b0;
      s_nxt.rsp_v = 1'b0;
      if (s_r.tv && link.h2d_ready) begin
         s_nxt.tv = 1'b0;
      end
      case (s_r.tx)
         HT_IDLE: begin
            if (i_cmd_valid) begin
               // never send a write the device must refuse, nor read a write-only id
               if (i_cmd_write ? napc_write_ok(i_cmd_id, i_cmd_len) :
                  napc_readable(i_cmd_id)) begin // RULE4 RULE8 RULE9
                  s_nxt.tx = HT_ID;
                  s_nxt.wr = i_cmd_write;
                  s_nxt.id = i_cmd_id;
                  s_nxt.len = i_cmd_write ? i_cmd_len : 8'h00;
                  s_nxt.pay = i_cmd_payload;
               end else begin
                  s_nxt.cmd_err = 1'b1;
               end
            end
         end
         HT_ID: begin
            if (load) begin
               s_nxt.tv = 1'b1;
               s_nxt.txd = s_r.id;
               s_nxt.tl = 1'b0;
               s_nxt.tx = HT_LEN;
            end
         end
         HT_LEN: begin
            if (load) begin
               s_nxt.tv = 1'b1;
               s_nxt.txd = s_r.len;
               s_nxt.tl = !s_r.wr;
               s_nxt.cnt = 8'h00;
               s_nxt.tx = s_r.wr ? HT_PAY : HT_IDLE;
            end
         end
         HT_PAY: begin
            if (load && (!rt_src || i_rtcm_valid)) begin
               s_nxt.tv = 1'b1;
               s_nxt.txd = rt_src ? i_rtcm_data : s_r.pay[s_r.cnt[3:0]]; // RULE8
               s_nxt.tl = (s_r.cnt + 8'h01 == s_r.len);
               s_nxt.cnt = s_r.cnt + 8'h01;
               if (s_r.cnt + 8'h01 == s_r.len) begin
                  s_nxt.tx = HT_IDLE;
               end
            end
         end
         default: s_nxt.tx = HT_IDLE;
      endcase
      if (link.d2h_valid) begin
         case (s_r.rx)
            HR_ID: begin
               s_nxt.rid = link.d2h_data;
               s_nxt.rx = link.d2h_last ? HR_ID : HR_LEN;
            end
            HR_LEN: begin
               s_nxt.rlen = link.d2h_data;
               s_nxt.rcnt = 8'h00;
               s_nxt.rbuf = '0;
               s_nxt.rx = link.d2h_last ? HR_ID : HR_PAY;
            end
            HR_PAY: begin
               s_nxt.rbuf[s_r.rcnt[4:0]] = link.d2h_data;
               s_nxt.rcnt = s_r.rcnt + 8'h01;
               if (link.d2h_last) begin
                  s_nxt.rx = HR_ID;
                  // geoid height goes up as-is; msl height and depth are derived downstream
                  if (s_r.rcnt + 8'h01 == s_r.rlen && s_r.rlen == napc_len(s_r.rid)) begin // RULE7
                     s_nxt.rsp_v = 1'b1;
                     s_nxt.rsp_id = s_r.rid;
                     s_nxt.rsp = s_nxt.rbuf;
                  end
               end
            end
            default: s_nxt.rx = HR_ID;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

//--- testbench/napc_link_chk.sv
// stream checks on the link between host and device ends
`timescale 1ns/1ps
module napc_link_chk (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_last,
   input wire logic d2h_valid,
   input wire logic d2h_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_last
);
   logic [8:0] hp_r;
   logic [8:0] dp_r;
   logic [7:0] hid_r;
   logic [7:0] hlen_r;
   logic [7:0] did_r;
   logic [7:0] dlen_r;
   logic hgo;
   logic dgo;
   assign hgo = h2d_valid && h2d_ready;
   assign dgo = d2h_valid && d2h_ready;
   function automatic logic [7:0] flen(input logic [7:0] id);
      case (id)
         8'h32, 8'h39: flen = 8'h0C;
         8'h33: flen = 8'h14;
         8'h34, 8'h35: flen = 8'h08;
         8'h36: flen = 8'h04;
         8'h3A: flen = 8'h10;
         default: flen = 8'h00;
      endcase
   endfunction
   // byte position in frame: 0 id, 1 length, then payload
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         hp_r <= 9'h000;
         dp_r <= 9'h000;
      end else begin
         if (hgo) hp_r <= h2d_last ? 9'h000 : hp_r + 9'h001;
         if (dgo) dp_r <= d2h_last ? 9'h000 : dp_r + 9'h001;
      end
      if (hgo && hp_r == 9'h000) hid_r <= h2d_data;
      if (hgo && hp_r == 9'h001) hlen_r <= h2d_data;
      if (dgo && dp_r == 9'h000) did_r <= d2h_data;
      if (dgo && dp_r == 9'h001) dlen_r <= d2h_data;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   chk_resp_len: assert property (dgo && dp_r == 9'h001 |-> d2h_data == flen(did_r))
      else $error("response length field wrong");
   chk_resp_last: assert property (dgo |->
      d2h_last == (dp_r > 9'h001 && dp_r == {1'b0, dlen_r} + 9'h001))
      else $error("response last flag misplaced");
   chk_odo_pad: assert property (dgo && did_r == 8'h33 && dp_r > 9'h012 |->
      d2h_data == 8'h00)
      else $error("odometer reserved byte not zero");
   chk_resp_time: assert property (hgo && h2d_last && hp_r == 9'h001 &&
      flen(hid_r) != 8'h00 |-> ##[1:40] d2h_valid)
      else $error("read request not answered");
   chk_host_len: assert property (hgo && hp_r == 9'h001 && h2d_data != 8'h00 |->
      hid_r == 8'h37 || h2d_data == flen(hid_r))
      else $error("write length wrong");
   chk_host_dir: assert property (hgo && hp_r == 9'h001 |->
      (h2d_data == 8'h00) ? flen(hid_r) != 8'h00 : hid_r inside {8'h35, 8'h37, 8'h39})
      else $error("illegal direction for id");
   chk_pay_last: assert property (hgo && hp_r > 9'h001 |->
      h2d_last == (hp_r == {1'b0, hlen_r} + 9'h001))
      else $error("request last flag misplaced");
   chk_h2d_hold: assert property (h2d_valid && !h2d_ready |=>
      h2d_valid && $stable(h2d_data) && $stable(h2d_last))
      else $error("stalled byte changed");
endmodule

//--- testbench/nav_aux_packet_payload_codec_tb.sv
// bench for both codec ends and a raw-frame link into a second device
`timescale 1ns/1ps
module nav_aux_packet_payload_codec_tb;
   logic clk;
   logic rst = 1'b1;
   logic cv = 1'b0;
   logic cw = 1'b0;
   logic [7:0] cid = 8'h00;
   logic [7:0] cl = 8'h00;
   logic [95:0] cp = '0;
   logic crdy, cerr, rv, rtr, drv, wfix, wval, dupd, dupd2, e;
   logic [7:0] rid, drd;
   logic [159:0] rp;
   logic [31:0] dep, dsd, dep2;
   logic [95:0] wfv;
   logic rtv = 1'b1;
   logic [7:0] rtd = 8'hA0;
   logic drr = 1'b0;
   logic air = 1'b0;
   logic [95:0] mag = 96'h4142434445464748494A4B4C;
   logic [159:0] odo = 160'hFFFFFF01_3F800000_40000000_40400000_00000007;
   logic [63:0] tim = 64'h000F4240_65000000;
   logic [31:0] geo = 32'hC1F00000;
   logic [95:0] wnd = 96'h11111111_22222222_33333333;
   logic [127:0] hv = 128'h3D000000_3D800000_3E000000_3E800000;
   logic [16:0] bad[4] = '{17'h1320C, 17'h13504, 17'h03700, 17'h13700};
   logic [7:0] got[$];
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int upd2 = 0;
   int n;
   napc_link_if link();
   napc_link_if link2();
   napc_host u_napc_host (.i_sys_clk(clk), .i_reset(rst), .link(link), .i_cmd_valid(cv),
      .o_cmd_ready(crdy), .i_cmd_write(cw), .i_cmd_id(cid), .i_cmd_len(cl),
      .i_cmd_payload(cp), .o_cmd_err(cerr), .i_rtcm_valid(rtv), .i_rtcm_data(rtd),
      .o_rtcm_ready(rtr), .o_rsp_valid(rv), .o_rsp_id(rid), .o_rsp_payload(rp));
   napc_device u_napc_device (.i_sys_clk(clk), .i_reset(rst), .link(link), .i_mag_xyz(mag),
      .i_odo_state(odo), .i_ext_time(tim), .i_geoid_height(geo), .i_wind_est(wnd),
      .i_heave(hv), .i_air_data_valid(air), .o_depth(dep), .o_depth_sd(dsd),
      .o_depth_update(dupd), .o_wind_fixed_val(wfv), .o_wind_fixed(wfix),
      .o_wind_valid(wval), .o_rtcm_valid(drv), .o_rtcm_data(drd), .i_rtcm_ready(drr));
   napc_device u_napc_device_2 (.i_sys_clk(clk), .i_reset(rst), .link(link2),
      .i_mag_xyz(mag), .i_odo_state(odo), .i_ext_time(tim), .i_geoid_height(geo),
      .i_wind_est(wnd), .i_heave(hv), .i_air_data_valid(air), .o_depth(dep2),
      .o_depth_sd(), .o_depth_update(dupd2), .o_wind_fixed_val(), .o_wind_fixed(),
      .o_wind_valid(), .o_rtcm_valid(), .o_rtcm_data(), .i_rtcm_ready(1'b1));
   napc_link_chk u_napc_link_chk (.i_sys_clk(clk), .i_reset(rst),
      .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .h2d_data(link.h2d_data),
      .h2d_last(link.h2d_last), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready),
      .d2h_data(link.d2h_data), .d2h_last(link.d2h_last));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // slow sink so the device fifo fills and the host must stall
   always @(posedge clk) begin
      cyc++;
      drr <= (cyc % 8 == 0);
      if (rtv && rtr) rtd <= rtd + 8'h01;
      if (drv && drr) got.push_back(drd);
      if (dupd2 === 1'b1) upd2++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test;
      end
   end
   task automatic check(input logic [159:0] seen, input logic [159:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic send(input logic w, input logic [7:0] id, input logic [7:0] len,
         input logic [95:0] pay);
      cv <= 1'b1;
      cw <= w;
      cid <= id;
      cl <= len;
      cp <= pay;
      do @(posedge clk); while (crdy !== 1'b1);
      cv <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] id, input logic [159:0] exp);
      send(1'b0, id, 8'h00, 96'h0);
      do @(posedge clk); while (rv !== 1'b1);
      check(rid, id);
      check(rp, exp);
   endtask
   // raw frames, may end early or late, for the second device
   task automatic pkt2(input logic [7:0] id, input logic [7:0] len, input int nb);
      for (int k = 0; k < nb + 2; k++) begin
         link2.h2d_valid <= 1'b1;
         link2.h2d_data <= (k == 0) ? id : (k == 1) ? len : 8'(8'h10 + k);
         link2.h2d_last <= (k == nb + 1);
         do @(posedge clk); while (link2.h2d_ready !== 1'b1);
      end
      link2.h2d_valid <= 1'b0;
      link2.h2d_data <= ~link2.h2d_data;
      @(posedge clk);
   endtask
   initial begin
      link2.h2d_valid <= 1'b0;
      link2.h2d_data <= 8'h00;
      link2.h2d_last <= 1'b0;
      link2.d2h_ready <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(8'h35, 160'h0);
      rd(8'h32, {64'h0, mag});
      rd(8'h33, {24'h0, odo[135:0]});
      rd(8'h34, {96'h0, tim});
      rd(8'h36, {128'h0, geo});
      check(rp[31:0], 32'hC1F00000);
      rd(8'h39, {64'h0, wnd});
      rd(8'h3A, {32'h0, hv});
      $display("reads done");
      send(1'b1, 8'h35, 8'h08, {32'h0, 64'h3F000000_41A00000});
      do @(posedge clk); while (dupd !== 1'b1);
      check({dsd, dep}, 64'h3F000000_41A00000);
      rd(8'h35, {96'h0, 64'h3F000000_41A00000});
      check(wfix, 1'b0);
      send(1'b1, 8'h39, 8'h0C, 96'h3E800000_C0000000_40400000);
      do @(posedge clk); while (wfix !== 1'b1);
      check(wfv, 96'h3E800000_C0000000_40400000);
      rd(8'h39, {64'h0, 96'h3E800000_C0000000_40400000});
      check(wval, 1'b0);
      air <= 1'b1;
      @(posedge clk);
      check(wval, 1'b0);
      @(posedge clk);
      check(wval, 1'b1);
      $display("writes done");
      foreach (bad[i]) begin
         send(bad[i][16], bad[i][15:8], bad[i][7:0], 96'h0);
         e = 1'b0;
         repeat (3) begin
            @(posedge clk);
            e = e | (cerr === 1'b1);
         end
         check(e, 1'b1);
      end
      send(1'b1, 8'h37, 8'h30, 96'h0);
      while (got.size() < 48) @(posedge clk);
      foreach (got[i]) check(got[i], 8'(8'hA0 + i));
      $display("refusals and corrections done");
      pkt2(8'h35, 8'h08, 6);
      pkt2(8'h35, 8'h04, 4);
      pkt2(8'h32, 8'h0C, 12);
      pkt2(8'h35, 8'h08, 10);
      repeat (40) @(posedge clk);
      check({upd2, dep2}, 64'h0);
      pkt2(8'h35, 8'h08, 8);
      repeat (40) @(posedge clk);
      check({upd2, dep2}, {32'h1, 32'h15141312});
      $display("bad frames done");
      // answer held back so the receive buffer fills; frames must come out in order
      link2.d2h_ready <= 1'b0;
      pkt2(8'h32, 8'h00, 0);
      repeat (4) @(posedge clk);
      n = 0;
      for (int j = 0; j < 33; j++) begin
         link2.h2d_valid <= 1'b1;
         link2.h2d_data <= (j >= 31) ? 8'h00 : (j % 10 == 0) ? 8'h35 :
            (j % 10 == 1) ? 8'h08 : 8'(j);
         link2.h2d_last <= (j >= 31) || (j % 10 == 9);
         @(posedge clk);
         if (link2.h2d_ready === 1'b1) n++;
      end
      check(n, 32);
      check(link2.h2d_ready, 1'b0);
      link2.d2h_ready <= 1'b1;
      do @(posedge clk); while (link2.h2d_ready !== 1'b1);
      link2.h2d_valid <= 1'b0;
      repeat (80) @(posedge clk);
      check({upd2, dep2}, {32'h4, 32'h19181716});
      check(link2.h2d_ready, 1'b1);
      $display("buffer done");
      stop_test;
   end
endmodule
